// >>> logic/host_port.sv
// parallel host port with register file, latched status and start-up control
`timescale 1ns/10ps
`include "host_port_map.svh"

module host_port
  import host_port_pkg::*;
#(
  parameter logic [15:0] PART_ID = `PART_ID_DEFAULT // value is arbitrary
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [8:0] host_addr,
  input wire logic addr_lsb_or_swap_select,
  input wire logic bus_width_select,
  input wire logic [15:0] data_in,
  input wire logic [15:0] status_event,
  output logic [15:0] data_out,
  output logic data_oe_lo,
  output logic data_oe_hi,
  output logic rdy_n,
  output logic global_reset_active,
  output logic global_datapath_reset,
  output logic port_datapath_reset,
  output logic port_power_down,
  output logic [1:0] system_interface_type,
  output logic [1:0] system_bus_width,
  output logic [15:0] clock_rate_adapter_config,
  output logic [15:0] global_io_config,
  output logic payload_ais_disable,
  output logic line_ais_disable,
  output logic hdlc_attach_select,
  output logic line_interface_enable,
  output logic jitter_attenuator_rx,
  output logic [5:0] framing_mode_field,
  output logic plcp_enable,
  output logic tx_line_enable,
  output logic cell_processing_route,
  output logic tx_hec_carry,
  output logic rx_hec_carry,
  output logic loop_timing_enable,
  output logic tx_clock_source_select,
  output logic [15:0] latched_status,
  output logic [7:0] tuning_a,
  output logic [7:0] tuning_b
);

  state_type s;
  state_type next_s;

  logic wide;
  logic swap;
  logic strobe;
  logic lane_hi;
  logic lane_lo;
  logic [9:0] word;
  logic hit;
  logic [3:0] lat;
  logic [15:0] rv;
  logic [15:0] wd;
  logic [15:0] bm;
  logic [15:0] clr;
  logic complete;
  logic rst_keep;

  assign wide = s.width_s2;
  assign swap = wide & s.lsb_s2;
  assign strobe = ~s.cs_s2 & (~s.rd_s2 | ~s.wr_s2);
  assign lane_hi = wide | s.lsb_s2;
  assign lane_lo = wide | ~s.lsb_s2;
  assign word = {s.addr_s2, 1'b0};
  assign bm = {{8{lane_hi}}, {8{lane_lo}}};
  assign complete = (s.fsm == ST_WAIT) && (s.count == 4'h0);

  // global registers answer fast, port and tuning registers slow
  always_comb
  begin
    hit = 1'b1;
    lat = `LAT_FAST;
    rv = 16'h0000;
    case (word)
      `OFS_PART_ID: rv = PART_ID;
      `OFS_GCR1: rv = s.gcr1;
      `OFS_GCR2: rv = s.gcr2;
      `OFS_GIOCR: rv = s.giocr;
      `OFS_LATCHED: rv = s.latched;
      `OFS_PCR1:
      begin
        rv = s.pcr1;
        lat = `LAT_SLOW;
      end
      `OFS_PCR2:
      begin
        rv = s.pcr2;
        lat = `LAT_SLOW;
      end
      `OFS_PCR3:
      begin
        rv = s.pcr3;
        lat = `LAT_SLOW;
      end
      `OFS_PCR4:
      begin
        rv = s.pcr4;
        lat = `LAT_SLOW;
      end
      (`OFS_TUNE_A & `WORD_MASK):
      begin
        rv = {s.tune_a, 8'h00};
        lat = `LAT_SLOW;
      end
      (`OFS_TUNE_B & `WORD_MASK):
      begin
        rv = {s.tune_b, 8'h00};
        lat = `LAT_SLOW;
      end
      default: hit = 1'b0;
    endcase
  end

  always_comb
  begin
    next_s = s;
    rst_keep = 1'b0;
    // pins cross from the host's untimed bus
    next_s.cs_s1 = cs_n;
    next_s.cs_s2 = s.cs_s1;
    next_s.rd_s1 = rd_n;
    next_s.rd_s2 = s.rd_s1;
    next_s.wr_s1 = wr_n;
    next_s.wr_s2 = s.wr_s1;
    next_s.lsb_s1 = addr_lsb_or_swap_select;
    next_s.lsb_s2 = s.lsb_s1;
    next_s.width_s1 = bus_width_select;
    next_s.width_s2 = s.width_s1;
    next_s.addr_s1 = host_addr;
    next_s.addr_s2 = s.addr_s1;
    next_s.din_s1 = data_in;
    next_s.din_s2 = s.din_s1;

    if (wide)
      wd = swap ? {s.din_s2[7:0], s.din_s2[15:8]} : s.din_s2;
    else
      wd = {s.din_s2[7:0], s.din_s2[7:0]};

    clr = 16'h0000;
    if (complete && (word == `OFS_LATCHED))
    begin
      if (s.is_read && s.gcr1[`GCR1_LCRE])
        clr = bm;
      else if (!s.is_read && !s.gcr1[`GCR1_LCRE])
        clr = wd & bm;
    end
    // a new event wins over a clear in the same cycle
    next_s.latched = (s.latched & ~clr) | status_event;

    case (s.fsm)
      ST_IDLE:
      begin
        if (strobe)
        begin
          next_s.is_read = ~s.rd_s2;
          next_s.count = lat;
          next_s.fsm = hit ? ST_WAIT : ST_STALL;
        end
      end
      ST_WAIT:
      begin
        if (s.count != 4'h0)
          next_s.count = s.count - 4'h1;
        else
        begin
          next_s.rdy_n = 1'b0;
          next_s.fsm = ST_DONE;
          if (s.is_read)
          begin
            next_s.oe_lo = 1'b1;
            next_s.oe_hi = wide;
            if (wide)
              next_s.dout = swap ? {rv[7:0], rv[15:8]} : rv;
            else
              next_s.dout = {8'h00, s.lsb_s2 ? rv[15:8] : rv[7:0]};
          end
          else
          begin
            case (word)
              `OFS_GCR1: next_s.gcr1 = (s.gcr1 & ~bm) | (wd & bm);
              `OFS_GCR2: next_s.gcr2 = (s.gcr2 & ~bm) | (wd & bm);
              `OFS_GIOCR: next_s.giocr = (s.giocr & ~bm) | (wd & bm);
              `OFS_PCR1: next_s.pcr1 = (s.pcr1 & ~bm) | (wd & bm);
              `OFS_PCR2: next_s.pcr2 = (s.pcr2 & ~bm) | (wd & bm);
              `OFS_PCR3: next_s.pcr3 = (s.pcr3 & ~bm) | (wd & bm);
              `OFS_PCR4: next_s.pcr4 = (s.pcr4 & ~bm) | (wd & bm);
              (`OFS_TUNE_A & `WORD_MASK):
              begin
                if (lane_hi)
                  next_s.tune_a = wd[15:8];
              end
              (`OFS_TUNE_B & `WORD_MASK):
              begin
                if (lane_hi)
                  next_s.tune_b = wd[15:8];
              end
              default:
              begin
                // identification and latched words take no stored write
              end
            endcase
          end
        end
      end
      ST_DONE:
      begin
        // ready stays low until the host lets go of the strobe
        if (!strobe)
        begin
          next_s.rdy_n = 1'b1;
          next_s.oe_lo = 1'b0;
          next_s.oe_hi = 1'b0;
          next_s.fsm = ST_IDLE;
        end
      end
      ST_STALL:
      begin
        if (!strobe)
          next_s.fsm = ST_IDLE;
      end
      default: next_s.fsm = ST_IDLE;
    endcase

    // while the reset bit stands every register but the bit itself is forced
    if (s.gcr1[`GCR1_RST])
    begin
      rst_keep = next_s.gcr1[`GCR1_RST];
      next_s.gcr1 = `GCR1_RESET;
      next_s.gcr1[`GCR1_RST] = rst_keep;
      next_s.gcr2 = `GCR2_RESET;
      next_s.giocr = `GIOCR_RESET;
      next_s.pcr1 = `PCR1_RESET;
      next_s.pcr2 = `PCR2_RESET;
      next_s.pcr3 = `PCR3_RESET;
      next_s.pcr4 = `PCR4_RESET;
      next_s.tune_a = `TUNE_RESET;
      next_s.tune_b = `TUNE_RESET;
      next_s.latched = 16'h0000;
    end

    next_s.payload_ais_off = (next_s.pcr1[`PCR1_PAIS_LO +: 3] == `PAIS_OFF);
    next_s.line_ais_off = (next_s.pcr1[`PCR1_LAIS_LO +: 2] == `LAIS_OFF);
    next_s.liu_on = (next_s.pcr2[`PCR2_LM_LO +: 3] == `LM_LIU_JA_RX);
    next_s.ja_rx = (next_s.pcr2[`PCR2_LM_LO +: 3] == `LM_LIU_JA_RX);
    next_s.cell_route = next_s.gcr1[`IFC_POS_BIT] & next_s.pcr2[`PCR2_CELL_PROCESSING_ENABLE];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.cs_s1 <= 1'b1;
      s.cs_s2 <= 1'b1;
      s.rd_s1 <= 1'b1;
      s.rd_s2 <= 1'b1;
      s.wr_s1 <= 1'b1;
      s.wr_s2 <= 1'b1;
      s.fsm <= ST_IDLE;
      s.rdy_n <= 1'b1;
      s.gcr1 <= `GCR1_RESET;
      s.gcr2 <= `GCR2_RESET;
      s.giocr <= `GIOCR_RESET;
      s.pcr1 <= `PCR1_RESET;
      s.pcr2 <= `PCR2_RESET;
      s.pcr3 <= `PCR3_RESET;
      s.pcr4 <= `PCR4_RESET;
      s.tune_a <= `TUNE_RESET;
      s.tune_b <= `TUNE_RESET;
    end
    else
      s <= next_s;
  end

  assign data_out = s.dout;
  assign data_oe_lo = s.oe_lo;
  assign data_oe_hi = s.oe_hi;
  assign rdy_n = s.rdy_n;
  assign global_reset_active = s.gcr1[`GCR1_RST];
  assign global_datapath_reset = s.gcr1[`GCR1_DPRST];
  assign port_datapath_reset = s.pcr1[`PCR1_DPRST];
  assign port_power_down = s.pcr1[`PCR1_PD];
  assign system_interface_type = s.gcr1[`GCR1_IFC_LO +: 2];
  assign system_bus_width = s.gcr1[`GCR1_BUSW_LO +: 2];
  assign clock_rate_adapter_config = s.gcr2;
  assign global_io_config = s.giocr;
  assign payload_ais_disable = s.payload_ais_off;
  assign line_ais_disable = s.line_ais_off;
  assign hdlc_attach_select = s.pcr1[`PCR1_HDLC_ATTACH_SELECT];
  assign line_interface_enable = s.liu_on;
  assign jitter_attenuator_rx = s.ja_rx;
  assign framing_mode_field = s.pcr2[`PCR2_FM_LO +: 6];
  assign plcp_enable = s.pcr2[`PCR2_PLCP];
  assign tx_line_enable = s.pcr2[`PCR2_TX_LINE_ENABLE];
  assign cell_processing_route = s.cell_route;
  assign tx_hec_carry = s.pcr4[`PCR4_THEC];
  assign rx_hec_carry = s.pcr4[`PCR4_RHEC];
  assign loop_timing_enable = s.pcr3[`PCR3_LOOP_TIMING_ENABLE];
  assign tx_clock_source_select = s.pcr3[`PCR3_TX_CLOCK_SOURCE_SELECT];
  assign latched_status = s.latched;
  assign tuning_a = s.tune_a;
  assign tuning_b = s.tune_b;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_ready_after_wait: assert property ($fell(s.rdy_n) |-> $past(s.fsm) == ST_WAIT)
    else $error("ready fell without a finished access");
  a_unmapped_no_ready: assert property (s.fsm == ST_STALL |-> s.rdy_n)
    else $error("ready given for an unmapped address");
  a_fast_latency: assert property ((s.fsm == ST_IDLE && strobe && hit && lat == `LAT_FAST)
    |-> s.rdy_n [*4] ##1 !s.rdy_n)
    else $error("fast location latency wrong");
  a_slow_latency: assert property ((s.fsm == ST_IDLE && strobe && hit && lat == `LAT_SLOW)
    |-> ##8 !s.rdy_n)
    else $error("slow location latency wrong");
  a_byte_upper_quiet: assert property (s.oe_hi |-> s.width_s2 && s.oe_lo)
    else $error("upper lines driven on byte bus");
  a_read_clears: assert property ((complete && s.is_read && s.gcr1[`GCR1_LCRE] && word == `OFS_LATCHED
    && wide && status_event == 16'h0000 && !s.gcr1[`GCR1_RST]) |=> s.latched == 16'h0000)
    else $error("read did not clear latched status");
  a_write_clears: assert property ((complete && !s.is_read && !s.gcr1[`GCR1_LCRE]
    && word == `OFS_LATCHED && !s.gcr1[`GCR1_RST])
    |=> s.latched == (($past(s.latched) & ~$past(clr)) | $past(status_event)))
    else $error("write clear touched wrong bits");
  a_event_kept: assert property ((status_event != 16'h0000 && !s.gcr1[`GCR1_RST])
    |=> (s.latched & $past(status_event)) == $past(status_event))
    else $error("status event lost");
  a_reset_bit_holds: assert property (s.gcr1[`GCR1_RST] |=> s.pcr1 == `PCR1_RESET
    && s.pcr2 == `PCR2_RESET)
    else $error("registers not held at default");
  a_swap_read: assert property ((complete && s.is_read && swap)
    |=> data_out == {$past(rv[7:0]), $past(rv[15:8])})
    else $error("byte swap not applied");

  c_read_done: cover property (complete && s.is_read ##1 !s.rdy_n);
  c_write_done: cover property (complete && !s.is_read);
  c_unmapped: cover property (s.fsm == ST_STALL);
  c_reset_bit: cover property (s.gcr1[`GCR1_RST] ##1 !s.gcr1[`GCR1_RST]);

endmodule

// >>> logic/host_port_map.svh
// register offsets, field positions, reset values and access latencies of the host port
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

`define OFS_PART_ID 10'h000
`define OFS_GCR1 10'h002
`define OFS_GCR2 10'h004
`define OFS_GIOCR 10'h00a
`define OFS_LATCHED 10'h010
`define OFS_PCR1 10'h040
`define OFS_PCR2 10'h042
`define OFS_PCR3 10'h044
`define OFS_PCR4 10'h046
`define OFS_TUNE_A 10'h20b
`define OFS_TUNE_B 10'h20f
`define WORD_MASK 10'h3fe

`define GCR1_RST 0
`define GCR1_DPRST 1
`define GCR1_LCRE 2
`define GCR1_IFC_LO 8
`define GCR1_BUSW_LO 10
`define IFC_POS_BIT 9

`define PCR1_DPRST 0
`define PCR1_PD 1
`define PCR1_HDLC_ATTACH_SELECT 2
`define PCR1_LAIS_LO 10
`define PCR1_PAIS_LO 12
`define PCR2_TX_LINE_ENABLE 0
`define PCR2_FM_LO 1
`define PCR2_PLCP 2
`define PCR2_LM_LO 8
`define PCR2_CELL_PROCESSING_ENABLE 11
`define PCR3_LOOP_TIMING_ENABLE 0
`define PCR3_TX_CLOCK_SOURCE_SELECT 1
`define PCR4_THEC 0
`define PCR4_RHEC 1

`define LM_LIU_JA_RX 3'b011
`define PAIS_OFF 3'b111
`define LAIS_OFF 2'b11

`define GCR1_RESET 16'h0002
`define GCR2_RESET 16'h0000
`define GIOCR_RESET 16'h0000
`define PCR1_RESET 16'h0003
`define PCR2_RESET 16'h0000
`define PCR3_RESET 16'h0000
`define PCR4_RESET 16'h0000
`define TUNE_RESET 8'h00
`define PART_ID_DEFAULT 16'h0a5a

`define LAT_FAST 4'h2
`define LAT_SLOW 4'h6

`endif

// >>> logic/host_port_pkg.sv
// types of the host port: access states and the registered state record
package host_port_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11,
    ST_STALL = 2'b10
  } access_state_type;

  typedef struct packed {
    logic cs_s1, cs_s2, rd_s1, rd_s2, wr_s1, wr_s2, lsb_s1, lsb_s2, width_s1, width_s2;
    logic [8:0] addr_s1, addr_s2;
    logic [15:0] din_s1, din_s2;
    access_state_type fsm;
    logic [3:0] count;
    logic is_read;
    logic rdy_n;
    logic [15:0] dout;
    logic oe_lo, oe_hi;
    logic [15:0] gcr1, gcr2, giocr, pcr1, pcr2, pcr3, pcr4, latched;
    logic [7:0] tune_a, tune_b;
    logic payload_ais_off, line_ais_off, liu_on, ja_rx, cell_route;
  } state_type;

endpackage

// >>> sim/host_cpu_model.sv
// host processor model for the asynchronous register port
`timescale 1ns/10ps
module host_cpu_model
(
  input wire logic clk,
  input wire logic wide,
  input wire logic swap,
  input wire logic [15:0] data_out,
  input wire logic data_oe_lo,
  input wire logic data_oe_hi,
  input wire logic rdy_n,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [8:0] host_addr,
  output logic addr_lsb_or_swap_select,
  output logic [15:0] data_in
);
  logic lsb8 = 1'b0;
  // swap level only moves under pin reset
  assign addr_lsb_or_swap_select = wide ? swap : lsb8;
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    host_addr = 9'h000;
    data_in = 16'h0000;
  end
  // cyc stops at 40 when ready never comes
  task automatic access(input logic w, input logic [9:0] a, input logic [15:0] d,
    output logic [15:0] q, output logic [1:0] hi, output int cyc);
    @(posedge clk);
    host_addr <= a[9:1];
    lsb8 <= a[0];
    data_in <= d;
    cs_n <= 1'b0;
    rd_n <= w;
    wr_n <= !w;
    cyc = 0;
    do
    begin
      @(posedge clk);
      cyc++;
    end
    while (rdy_n !== 1'b0 && cyc < 40);
    q = data_out;
    hi = {data_oe_hi, data_oe_lo};
    // strobe ends at the edge that saw ready, or at the 40th edge when ready never comes
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    // released data lines must not look held
    data_in <= ~d;
    repeat (40) if (rdy_n !== 1'b1) @(posedge clk);
    @(posedge clk);
  endtask
endmodule

// >>> sim/host_bus_port_and_init_control_tb_top.sv
// self-checking bench of the host register port
`timescale 1ns/10ps
`include "host_port_map.svh"
module host_bus_port_and_init_control_tb_top;
  localparam logic [15:0] ID = 16'h3c71; // value is arbitrary
  logic clk, sys_rst, cs_n, rd_n, wr_n, addr_lsb_or_swap_select, bus_width_select, swap;
  logic [8:0] host_addr;
  logic [15:0] data_in, status_event, data_out, latched_status, clock_rate_adapter_config, global_io_config;
  logic data_oe_lo, data_oe_hi, rdy_n, global_reset_active, global_datapath_reset, port_datapath_reset;
  logic port_power_down, payload_ais_disable, line_ais_disable, hdlc_attach_select, line_interface_enable;
  logic jitter_attenuator_rx, plcp_enable, tx_line_enable, cell_processing_route, tx_hec_carry, rx_hec_carry;
  logic loop_timing_enable, tx_clock_source_select;
  logic [1:0] hi;
  logic [1:0] system_interface_type, system_bus_width;
  logic [5:0] framing_mode_field;
  logic [7:0] tuning_a, tuning_b;
  logic [15:0] rdata, v, m, r;
  int cyc, f, n_fail = 0, n_tests = 0;

  host_port #(.PART_ID(ID)) i_dut (.clk, .sys_rst, .cs_n, .rd_n, .wr_n, .host_addr,
    .addr_lsb_or_swap_select, .bus_width_select, .data_in, .status_event, .data_out, .data_oe_lo,
    .data_oe_hi, .rdy_n, .global_reset_active, .global_datapath_reset, .port_datapath_reset,
    .port_power_down, .system_interface_type, .system_bus_width, .clock_rate_adapter_config,
    .global_io_config, .payload_ais_disable, .line_ais_disable, .hdlc_attach_select,
    .line_interface_enable, .jitter_attenuator_rx, .framing_mode_field, .plcp_enable, .tx_line_enable,
    .cell_processing_route, .tx_hec_carry, .rx_hec_carry, .loop_timing_enable, .tx_clock_source_select,
    .latched_status, .tuning_a, .tuning_b);

  host_cpu_model i_host (.clk, .wide(bus_width_select), .swap, .data_out, .data_oe_lo, .data_oe_hi, .rdy_n,
    .cs_n, .rd_n, .wr_n, .host_addr, .addr_lsb_or_swap_select, .data_in);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check_val(input string s, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask

  function automatic logic [15:0] lanes(input logic [15:0] x);
    return swap ? {x[7:0], x[15:8]} : x;
  endfunction

  task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d);
    i_host.access(w, a, d, rdata, hi, cyc);
  endtask

  task automatic wr16(input logic [9:0] a, input logic [15:0] x);
    acc(1'b1, a, lanes(x));
  endtask

  task automatic rd16(input string s, input logic [9:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    check_val(s, lanes(e), rdata);
  endtask

  // mode pins change only while reset holds the port
  task automatic pin_reset(input logic w, input logic s);
    @(posedge clk);
    sys_rst <= 1'b1;
    bus_width_select <= w;
    swap <= s;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  initial
  begin
    #200000;
    n_fail++;
    give_verdict();
  end

  initial
  begin
    sys_rst = 1'b1;
    bus_width_select = 1'b1;
    swap = 1'b0;
    status_event = 16'h0000;
    void'($urandom(32'he320d1be));
    pin_reset(1'b1, 1'b0);
    rd16("id", `OFS_PART_ID, ID);
    rd16("gcr1", `OFS_GCR1, 16'h0002);
    rd16("pcr1", `OFS_PCR1, 16'h0003);
    rd16("pcr2", `OFS_PCR2, 16'h0000);
    check_val("sbw0", 16'h0000, 16'(system_bus_width));
    check_val("gdpr", 16'h0001, 16'(global_datapath_reset));
    // fifo level and port-address words lie beyond this port, so no fifo reset pulse is owed here
    wr16(`OFS_PCR2, 16'h0800);
    for (int i = 0; i < 12; i++)
    begin
      wr16(`OFS_GCR1, {4'h0, 2'(i / 4), 2'(i % 4), 8'h00});
      check_val("ifc", 16'(i % 4), 16'(system_interface_type));
      check_val("sbw", 16'(i / 4), 16'(system_bus_width));
      check_val("cell", 16'(i % 4 > 1), 16'(cell_processing_route));
    end
    for (int i = 0; i < 8; i++)
    begin
      r = 16'($urandom);
      v = {5'h00, 3'(i), 1'b0, r[5:0], r[6]};
      wr16(`OFS_PCR2, v);
      rd16("pcr2", `OFS_PCR2, v);
      check_val("lie", 16'(i == 3), 16'(line_interface_enable));
      check_val("ja", 16'(i == 3), 16'(jitter_attenuator_rx));
      check_val("fm", 16'(r[5:0]), 16'(framing_mode_field));
      check_val("plcp", 16'(r[1]), 16'(plcp_enable));
      check_val("tx_line_enable", 16'(r[6]), 16'(tx_line_enable));
      v = {1'b0, 3'(i), r[8:7], 7'h00, r[9], 2'b00};
      wr16(`OFS_PCR1, v);
      check_val("pais", 16'(i == 7), 16'(payload_ais_disable));
      check_val("lais", 16'(r[8:7] == 2'b11), 16'(line_ais_disable));
      check_val("hdlc", 16'(r[9]), 16'(hdlc_attach_select));
      check_val("pd", 16'h0000, 16'(port_power_down));
    end
    r = 16'($urandom);
    wr16(`OFS_PCR3, {14'h0, r[1:0]});
    wr16(`OFS_PCR4, {14'h0, r[3:2]});
    wr16(`OFS_TUNE_A, {r[15:8], 8'h00});
    wr16(`OFS_GCR2, r);
    wr16(`OFS_GIOCR, ~r);
    check_val("loop", 16'(r[0]), 16'(loop_timing_enable));
    check_val("csrc", 16'(r[1]), 16'(tx_clock_source_select));
    check_val("thec", 16'(r[2]), 16'(tx_hec_carry));
    check_val("rhec", 16'(r[3]), 16'(rx_hec_carry));
    check_val("tune", 16'(r[15:8]), 16'(tuning_a));
    check_val("cra", r, clock_rate_adapter_config);
    check_val("gio", ~r, global_io_config);
    rd16("id", `OFS_PART_ID, ID);
    f = cyc;
    rd16("pcr3", `OFS_PCR3, {14'h0, r[1:0]});
    check_val("lat", 16'(`LAT_SLOW - `LAT_FAST), 16'(cyc - f));
    acc(1'b0, 10'h100, 16'h0000);
    check_val("unmap", 16'h0028, 16'(cyc));
    r = 16'($urandom);
    @(posedge clk);
    status_event <= r;
    @(posedge clk);
    status_event <= 16'h0000;
    rd16("lat", `OFS_LATCHED, r);
    m = 16'($urandom);
    wr16(`OFS_LATCHED, m);
    rd16("woc", `OFS_LATCHED, r & ~m);
    wr16(`OFS_GCR1, 16'h0004);
    rd16("roc", `OFS_LATCHED, r & ~m);
    rd16("roc2", `OFS_LATCHED, 16'h0000);
    @(posedge clk);
    status_event <= 16'h8000;
    acc(1'b0, `OFS_LATCHED, 16'h0000);
    status_event <= 16'h0000;
    rd16("keep", `OFS_LATCHED, 16'h8000);
    status_event <= 16'h0100;
    @(posedge clk);
    status_event <= 16'h0000;
    wr16(`OFS_LATCHED, 16'h0100);
    rd16("wkeep", `OFS_LATCHED, 16'h0100);
    wr16(`OFS_GCR1, 16'h0001);
    check_val("grst", 16'h0001, 16'(global_reset_active));
    check_val("pdr", 16'h0001, 16'(port_datapath_reset));
    check_val("cra0", 16'h0000, clock_rate_adapter_config);
    check_val("gio0", 16'h0000, global_io_config);
    wr16(`OFS_GCR1, 16'h0000);
    check_val("grst0", 16'h0000, 16'(global_reset_active));
    check_val("gdpr1", 16'h0001, 16'(global_datapath_reset));
    rd16("pcr1", `OFS_PCR1, 16'h0003);
    pin_reset(1'b1, 1'b1);
    rd16("idsw", `OFS_PART_ID, ID);
    check_val("oehi", 16'h0003, 16'(hi));
    wr16(`OFS_PCR3, 16'h0002);
    check_val("sw", 16'h0001, 16'(tx_clock_source_select));
    pin_reset(1'b0, 1'b0);
    acc(1'b0, 10'h001, 16'h0000);
    check_val("idhi", {8'h00, ID[15:8]}, {8'h00, rdata[7:0]});
    check_val("oe8", 16'h0001, 16'(hi));
    acc(1'b0, 10'h000, 16'h0000);
    check_val("idlo", {8'h00, ID[7:0]}, {8'h00, rdata[7:0]});
    acc(1'b1, 10'h043, 16'h0003);
    check_val("lie8", 16'h0001, 16'(line_interface_enable));
    acc(1'b1, `OFS_TUNE_B, {8'h00, r[7:0]});
    check_val("tuneb", 16'(r[7:0]), 16'(tuning_b));
    give_verdict();
  end
endmodule
